/* logic/cfg_gen.sv */
// PCI configuration and interrupt-acknowledge cycle generator, local-bus register side
`timescale 1ns/1ps
module cfg_gen (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Local bus register port (same clock domain)
    input  wire logic        lb_req,
    input  wire logic        lb_we,
    input  wire logic [11:0] lb_addr,
    input  wire logic [1:0]  lb_size,
    input  wire logic [31:0] lb_wdata,
    output logic             lb_ack,
    output logic             lb_retry,
    output logic             lb_err,
    output logic [31:0]      lb_rdata,
    // PCI-side register port
    input  wire logic        pr_req,
    input  wire logic        pr_we,
    input  wire logic [11:0] pr_addr,
    input  wire logic [31:0] pr_wdata,
    output logic             pr_ack,
    output logic [31:0]      pr_rdata,
    // Master enable from the PCI control register
    input  wire logic        pci_master_enable_bit,
    input  wire logic        local_byte_order_bit,
    // Request to the PCI master engine
    output logic             pm_req,
    output logic [3:0]       pm_cmd,
    output logic [31:0]      pm_addr,
    output logic [3:0]       pm_be_n,
    output logic [31:0]      pm_wdata,
    input  wire logic        pm_done,
    input  wire logic [31:0] pm_rdata
);
    logic [31:0] cfg_addr_q;
    logic [31:0] config_payload_q;
    logic [31:0] interrupt_vector_value_q;
    cfg_gen_pkg::gen_state_t state_q;
    cfg_gen_pkg::gen_state_t state_d;
    logic        pend_we_q;
    logic        pend_iack_q;
    logic [11:0] pend_addr_q;
    logic        pm_req_q;
    logic [3:0]  pm_cmd_q;
    logic [31:0] pm_addr_q;
    logic [3:0]  pm_be_n_q;
    logic [31:0] pm_wdata_q;
    logic        lb_ack_q;
    logic        lb_retry_q;
    logic        lb_err_q;
    logic [31:0] lb_rdata_q;
    logic        pr_ack_q;
    logic [31:0] pr_rdata_q;

    function automatic logic [3:0] iack_be_n(input logic [1:0] size, input logic [1:0] a);
        logic [3:0] be;
        be = 4'hf;
        unique case (size)
            cfg_gen_pkg::SIZE_BYTE: be = 4'h1 << a;
            cfg_gen_pkg::SIZE_HALF: be = a[1] ? 4'hc : 4'h3;
            default:                be = 4'hf;
        endcase
        return ~be;
    endfunction

    wire hit_addr = lb_addr == cfg_gen_pkg::OFF_CFG_ADDR;
    wire hit_data = lb_addr == cfg_gen_pkg::OFF_CFG_DATA;
    wire hit_iack = lb_addr == cfg_gen_pkg::OFF_IACK;
    wire gen_hit  = hit_data || (hit_iack && !lb_we);
    // Byte order bit is deliberately unused: register data goes straight through
    wire unused_boc = local_byte_order_bit; // R10
    wire lb_bus_err = (hit_data || hit_iack) && !pci_master_enable_bit; // R11 R12
    wire same_req = lb_we == pend_we_q && lb_addr == pend_addr_q; // R18
    wire launch   = lb_req && gen_hit && !lb_bus_err && state_q == cfg_gen_pkg::ST_IDLE;
    wire complete = lb_req && gen_hit && !lb_bus_err && state_q == cfg_gen_pkg::ST_DONE
                    && same_req;

    // Type 0 address: one-hot select, zeros at 15:11, function, register, zeros at 1:0
    wire [15:0] idsel = 16'h0001 << cfg_addr_q[cfg_gen_pkg::DEV_LSB +: 4]; // R03
    wire [31:0] type0_addr = {idsel, 5'h00,
                              cfg_addr_q[cfg_gen_pkg::FUNC_LSB +: 3],
                              cfg_addr_q[cfg_gen_pkg::REG_LSB +: 6], 2'h0}; // R04
    wire [31:0] cfg_pci_addr = cfg_addr_q[cfg_gen_pkg::TYPE_BIT] ?
                               cfg_addr_q : type0_addr; // R01 R02
    wire [3:0]  cfg_cmd = lb_we ? cfg_gen_pkg::CMD_CFG_WR : cfg_gen_pkg::CMD_CFG_RD; // R07 R08
    wire [31:0] iack_pci_addr = {20'h00000, lb_addr}; // R15

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            cfg_gen_pkg::ST_IDLE: if (launch) state_d = cfg_gen_pkg::ST_REQ;
            cfg_gen_pkg::ST_REQ:  state_d = cfg_gen_pkg::ST_WAIT;
            cfg_gen_pkg::ST_WAIT: if (pm_done) state_d = cfg_gen_pkg::ST_DONE;
            cfg_gen_pkg::ST_DONE: if (complete) state_d = cfg_gen_pkg::ST_IDLE;
            default:              state_d = cfg_gen_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q     <= cfg_gen_pkg::ST_IDLE;
            pend_we_q   <= 1'b0;
            pend_iack_q <= 1'b0;
            pend_addr_q <= 12'h000;
        end else begin
            state_q <= state_d;
            if (launch) begin
                pend_we_q   <= lb_we;
                pend_iack_q <= hit_iack;
                pend_addr_q <= lb_addr;
            end
        end
    end

    // Request to the PCI master held from launch until the engine reports done
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pm_req_q   <= 1'b0;
            pm_cmd_q   <= cfg_gen_pkg::CMD_IACK;
            pm_addr_q  <= cfg_gen_pkg::RST_WORD;
            pm_be_n_q  <= 4'hf;
            pm_wdata_q <= cfg_gen_pkg::RST_WORD;
        end else if (launch) begin
            pm_req_q   <= 1'b1;
            pm_cmd_q   <= hit_iack ? cfg_gen_pkg::CMD_IACK : cfg_cmd; // R13
            pm_addr_q  <= hit_iack ? iack_pci_addr : cfg_pci_addr;
            pm_be_n_q  <= hit_iack ? iack_be_n(lb_size, lb_addr[1:0]) : 4'h0; // R14
            pm_wdata_q <= lb_wdata; // R10
        end else if (pm_done) begin
            pm_req_q <= 1'b0;
        end
    end

    // Registers; address bit 15 and other reserved bits never store
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_addr_q               <= cfg_gen_pkg::RST_WORD;
            config_payload_q         <= cfg_gen_pkg::RST_WORD;
            interrupt_vector_value_q <= cfg_gen_pkg::RST_WORD;
        end else begin
            if (lb_req && lb_we && hit_addr)
                cfg_addr_q <= lb_wdata & cfg_gen_pkg::CFG_ADDR_WMASK; // R05
            if (launch && lb_we)
                config_payload_q <= lb_wdata;
            if (state_q == cfg_gen_pkg::ST_WAIT && pm_done) begin
                if (pend_iack_q)
                    interrupt_vector_value_q <= pm_rdata; // R16
                else if (!pend_we_q)
                    config_payload_q <= pm_rdata; // R08
            end
        end
    end

    // Local bus answer: one-cycle ack, retry or error pulse one cycle after the request
    wire        lb_retry_d = lb_req && gen_hit && !lb_bus_err && !complete; // R09 R16
    wire        lb_err_d   = lb_req && lb_bus_err;
    wire        lb_ack_d   = lb_req && !lb_retry_d && !lb_err_d;
    wire [31:0] lb_read_mux = hit_addr ? cfg_addr_q :
                              hit_data ? config_payload_q :
                              hit_iack ? interrupt_vector_value_q : cfg_gen_pkg::RST_WORD;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lb_ack_q   <= 1'b0;
            lb_retry_q <= 1'b0;
            lb_err_q   <= 1'b0;
            lb_rdata_q <= cfg_gen_pkg::RST_WORD;
        end else begin
            lb_ack_q   <= lb_ack_d;
            lb_retry_q <= lb_retry_d;
            lb_err_q   <= lb_err_d;
            // Writes to the IACK register ack with no effect while master enable is set; with it clear they get a bus error
            if (lb_ack_d && !lb_we)
                lb_rdata_q <= lb_read_mux; // R10 R17
        end
    end

    // PCI-side access: address, data and IACK all read zero; writes are ignored
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pr_ack_q   <= 1'b0;
            pr_rdata_q <= cfg_gen_pkg::RST_WORD;
        end else begin
            pr_ack_q <= pr_req;
            if (pr_req && !pr_we)
                pr_rdata_q <= cfg_gen_pkg::RST_WORD; // R06 R17
        end
    end

    wire unused_pr = |{pr_addr, pr_wdata, unused_boc};

    assign lb_ack   = lb_ack_q;
    assign lb_retry = lb_retry_q;
    assign lb_err   = lb_err_q;
    assign lb_rdata = lb_rdata_q;
    assign pr_ack   = pr_ack_q;
    assign pr_rdata = pr_rdata_q;
    assign pm_req   = pm_req_q;
    assign pm_cmd   = pm_cmd_q;
    assign pm_addr  = pm_addr_q;
    assign pm_be_n  = pm_be_n_q;
    assign pm_wdata = pm_wdata_q;
endmodule

/* include/cfg_gen_pkg.sv */
// Constants and types for the PCI configuration and interrupt-acknowledge generator
// Notes on behaviour
// R01 - Type bit set: config access drives AD with the whole address register.
// R02 - Type bit clear: config access produces a Type 0 configuration cycle.
// R03 - Type 0: device number decoded one-hot onto AD[31:16].
// R04 - Type 0: AD[15:11] zero, function, register number, AD[1:0] zero.
// R05 - Address register bit 15 always reads and stays zero.
// R06 - PCI-side writes to config data ignored; PCI reads return zero.
// R07 - Local write to config data launches a PCI configuration write.
// R08 - Local read of config data launches PCI configuration read, data returned.
// R09 - Config data accesses are delayed transfers; local master retried until done.
// R10 - Register data never byte-swapped, whatever the byte-order setting.
// R11 - Config data access gives bus error when master enable is clear.
// R12 - Interrupt-acknowledge access gives bus error when master enable is clear.
// R13 - Local read of interrupt-acknowledge register issues a PCI IACK cycle.
// R14 - IACK byte enables come from transfer size lines and address bits 1:0.
// R15 - Local address of the IACK access is forwarded onto PCI address lines.
// R16 - IACK read is delayed; latched vector returned when master retries.
// R17 - Writes to IACK register ignored; PCI-side reads return zero.
// R18 - After retry the local master repeats the identical access to complete it.
package cfg_gen_pkg;
    localparam logic [11:0] OFF_CFG_ADDR = 12'h500;
    localparam logic [11:0] OFF_CFG_DATA = 12'h504;
    localparam logic [11:0] OFF_IACK     = 12'h508;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    // Writable bits of the address register: bus, device, function, register, type
    localparam logic [31:0] CFG_ADDR_WMASK = 32'h00ff_7ffd;
    localparam int TYPE_BIT = 0;
    localparam int REG_LSB  = 2;
    localparam int FUNC_LSB = 8;
    localparam int DEV_LSB  = 11;
    localparam int IDSEL_LSB = 16;
    // PCI command codes
    localparam logic [3:0] CMD_IACK   = 4'h0;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;
    // Transfer size encoding on the local bus
    localparam logic [1:0] SIZE_WORD = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_HALF = 2'h2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_REQ  = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_DONE = 4'b1000
    } gen_state_t;
endpackage

/* dv/cfg_gen_chk.sv */
// Concurrent checks on the generator ports
`timescale 1ns/1ps
module cfg_gen_chk (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        lb_req,
    input wire logic        lb_we,
    input wire logic [11:0] lb_addr,
    input wire logic        lb_ack,
    input wire logic        lb_retry,
    input wire logic        lb_err,
    input wire logic        pci_master_enable_bit,
    input wire logic        pm_req,
    input wire logic [3:0]  pm_cmd,
    input wire logic [31:0] pm_addr,
    input wire logic        pm_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic men = pci_master_enable_bit;
    wire logic iack = lb_addr == cfg_gen_pkg::OFF_IACK;
    wire logic gated = iack || lb_addr == cfg_gen_pkg::OFF_CFG_DATA;
    sequence s_iack_rd;
        lb_req && !lb_we && iack && men;
    endsequence
    sequence s_held;
        ##1 (lb_retry || lb_ack);
    endsequence
    a_one_answer: assert property (lb_req |=> $onehot({lb_ack, lb_retry, lb_err}))
        else $error("answer count");
    a_err_disabled: assert property (lb_req && !men && gated |=> lb_err)
        else $error("no bus error");
    a_iack_held: assert property (s_iack_rd |-> s_held)
        else $error("vector read refused");
    a_iack_wr_ack: assert property (lb_req && lb_we && iack && men |=>
        lb_ack && !$rose(pm_req))
        else $error("vector write");
    a_launch_retry: assert property ($rose(pm_req) |->
        lb_retry && $past(lb_req && men && gated))
        else $error("launch cause");
    a_iack_addr: assert property ($rose(pm_req) && pm_cmd == cfg_gen_pkg::CMD_IACK |->
        pm_addr == {20'h0, $past(lb_addr)} && $past(iack && !lb_we))
        else $error("vector address");
    a_req_hold: assert property (pm_req && !pm_done |=> pm_req && $stable(pm_addr))
        else $error("request dropped");
    a_done_drops: assert property (pm_done |=> !pm_req)
        else $error("request held");
endmodule
bind cfg_gen cfg_gen_chk u_cfg_gen_chk (.clk_sys(clk_sys), .rst_n(rst_n), .lb_req(lb_req),
    .lb_we(lb_we), .lb_addr(lb_addr), .lb_ack(lb_ack), .lb_retry(lb_retry), .lb_err(lb_err),
    .pci_master_enable_bit(pci_master_enable_bit), .pm_req(pm_req), .pm_cmd(pm_cmd),
    .pm_addr(pm_addr), .pm_done(pm_done));

/* dv/pm_model.sv */
// Behavioural PCI master engine with a settable answer delay
`timescale 1ns/1ps
module pm_model (
    input  wire logic        clk_sys,
    input  wire logic        pm_req,
    input  wire logic [31:0] pm_addr,
    input  wire logic [3:0]  dly,
    output logic             pm_done,
    output logic [31:0]      pm_rdata
);
    logic [3:0] cnt_q = 4'h0;
    initial pm_done = 1'b0;
    always @(posedge clk_sys) begin
        cnt_q <= pm_req && !pm_done ? cnt_q + 4'h1 : 4'h0;
        pm_done <= pm_req && !pm_done && cnt_q >= dly;
    end
    // Data only counts with done, so it keeps moving elsewhere
    assign pm_rdata = pm_done ? pm_addr ^ 32'h5a5a_a5a5 : {8{cnt_q}};
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the configuration cycle generator
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys = 1'b0, rst_n = 1'b0, lb_req = 1'b0, lb_we = 1'b0, men = 1'b0;
    logic        pr_req = 1'b0, pr_we = 1'b0, boc = 1'b0, pm_q = 1'b0;
    logic        lb_ack, lb_retry, lb_err, pr_ack, pm_req, pm_done;
    logic [11:0] lb_addr = 12'h0, pr_addr = 12'h0;
    logic [1:0]  lb_size = 2'h0;
    logic [3:0]  dly = 4'h0, pm_cmd, pm_be_n;
    logic [31:0] lb_wdata = 32'h0, v = 32'h0, lb_rdata, pr_rdata, pm_addr, pm_wdata, pm_rdata;
    logic [35:0] lbq[$];
    logic [71:0] pmq[$];
    integer      seed = 32'h05fe_7217;
    int          n_mismatch = 0, checked = 0, cyc = 0;
    cfg_gen u_cfg_gen (.clk_sys(clk_sys), .rst_n(rst_n), .lb_req(lb_req), .lb_we(lb_we),
        .lb_addr(lb_addr), .lb_size(lb_size), .lb_wdata(lb_wdata), .lb_ack(lb_ack),
        .lb_retry(lb_retry), .lb_err(lb_err), .lb_rdata(lb_rdata), .pr_req(pr_req),
        .pr_we(pr_we), .pr_addr(pr_addr), .pr_wdata(v), .pr_ack(pr_ack), .pr_rdata(pr_rdata),
        .pci_master_enable_bit(men), .local_byte_order_bit(boc), .pm_req(pm_req),
        .pm_cmd(pm_cmd), .pm_addr(pm_addr), .pm_be_n(pm_be_n), .pm_wdata(pm_wdata),
        .pm_done(pm_done), .pm_rdata(pm_rdata));
    pm_model u_pm_model (.clk_sys(clk_sys), .pm_req(pm_req), .pm_addr(pm_addr), .dly(dly),
        .pm_done(pm_done), .pm_rdata(pm_rdata));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic tally(input logic ok, input string m);
        checked++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic cmp_lb(input logic [35:0] e);
        tally({lb_ack, lb_retry, lb_err} === e[34:32] && (!e[35] || lb_rdata === e[31:0]),
            "answer");
    endtask
    task automatic cmp_pm(input logic [71:0] e);
        tally(pm_cmd === e[71:68] && pm_addr === e[67:36]
            && (pm_cmd != 4'h0 || pm_be_n === e[35:32])
            && (pm_cmd != 4'hb || pm_wdata === e[31:0]), "launch");
    endtask
    // PCI side is hit in the same cycle, so its writes must not disturb the local access
    task automatic acc(input logic we, input logic [11:0] a, input logic [1:0] sz,
            input logic [31:0] d, input logic [2:0] ans, input logic [31:0] ed);
        lbq.push_back({!we && ans[2], ans, ed});
        {lb_we, lb_addr, lb_size, lb_wdata, lb_req} = {we, a, sz, d, 1'b1};
        {pr_we, pr_addr, pr_req, boc} = {!we, a, 1'b1, 1'($random(seed))};
        @(negedge clk_sys) {lb_req, pr_req} = 2'b00;
        @(negedge clk_sys);
    endtask
    task automatic dl(input logic we, input logic [11:0] a, input logic [1:0] sz,
            input logic [31:0] d, input logic [71:0] pe, input logic bump);
        dly = 4'($random(seed)) & 4'h7;
        pmq.push_back(pe);
        acc(we, a, sz, d, 3'b010, 32'h0);
        for (int i = 0; i < 20 && !pm_done; i++) @(negedge clk_sys);
        @(negedge clk_sys);
        if (bump) acc(1'b0, a ^ 12'h00c, sz, d, 3'b010, 32'h0);
        acc(we, a, sz, d, 3'b100, pe[67:36] ^ 32'h5a5a_a5a5);
    endtask
    task automatic final_report();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(negedge clk_sys) begin
        cyc++;
        if (lb_ack || lb_retry || lb_err) cmp_lb(lbq.pop_front());
        if (pm_req && !pm_q) cmp_pm(pmq.pop_front());
        if (pr_ack) tally(pr_rdata === 32'h0, "pci read");
        pm_q = pm_req;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++)
            acc(i[0], i[1] ? 12'h508 : 12'h504, 2'h0, 32'h0, 3'b001, 32'h0);
        for (int i = 0; i < 2; i++) acc(1'b0, i ? 12'h50c : 12'h500, 2'h0, 32'h0, 3'b100, 32'h0);
        men = 1'b1;
        acc(1'b1, 12'h508, 2'h0, 32'hffff_ffff, 3'b100, 32'h0);
        $display("test refusals done");
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            v[14:11] = i[3:0];
            v[0] = 1'b0;
            acc(1'b1, 12'h500, 2'h0, v, 3'b100, 32'h0);
            acc(1'b0, 12'h500, 2'h0, 32'h0, 3'b100, v & cfg_gen_pkg::CFG_ADDR_WMASK);
            dl(i[0], 12'h504, 2'h0, ~v, {i[0] ? 4'hb : 4'ha, (32'h1 << (16 + i)) |
                (v & 32'h0000_07fc), 4'h0, ~v}, i == 5);
        end
        $display("test type 0 cycles done");
        v = $random(seed) | 32'h1;
        acc(1'b1, 12'h500, 2'h0, v, 3'b100, 32'h0);
        dl(1'b0, 12'h504, 2'h0, 32'h0, {4'ha, v & cfg_gen_pkg::CFG_ADDR_WMASK, 36'h0}, 1'b0);
        for (int s = 0; s < 3; s++) dl(1'b0, 12'h508, s[1:0], 32'h0, {4'h0, 32'h508,
            s == 0 ? 4'h0 : s == 1 ? 4'he : 4'hc, 32'h0}, s == 1);
        $display("test type 1 and vector cycles done");
        final_report();
    end
endmodule
